//--- rtl/pcc_cfg.svh
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH
// Register word indices; each register's byte address is four times its index.
`define PCC_ADDR_CTRL 8'hd8
`define PCC_ADDR_MODE 8'hd9
`define PCC_ADDR_CNT 8'he0
`define PCC_ADDR_WDOG 8'he4
`define PCC_ADDR_MCAP 8'he8
// Control register fields.
`define PCC_CTRL_OVF 7
`define PCC_CTRL_RUN 6
`define PCC_CTRL_WDF 5
// Mode register fields.
`define PCC_MODE_IDLE 7
`define PCC_MODE_WDEN 6
`define PCC_MODE_LOCK 5
`define PCC_MODE_UNUSED 4
`define PCC_MODE_SEL_LO 1
`define PCC_MODE_OVIE 0
// Reset values.
`define PCC_CTRL_RST 8'h00
`define PCC_MODE_RST 8'h40
// Time base divide ratios.
`define PCC_DIV12 4'd12
`define PCC_DIV4 4'd4
`define PCC_DIV8 3'd7
`define PCC_CNT_MAX 16'hffff
`endif

//--- rtl/pcc_pkg.sv
package pcc_pkg;
   // Time base choices of the counter.
   typedef enum logic [2:0] {
      PCC_TB_DIV12 = 3'b000,
      PCC_TB_DIV4 = 3'b001,
      PCC_TB_T0OVF = 3'b010,
      PCC_TB_EXTFALL = 3'b011,
      PCC_TB_SYSCLK = 3'b100,
      PCC_TB_EXTOSC = 3'b101,
      PCC_TB_RTC = 3'b110,
      PCC_TB_RSVD = 3'b111
   } pcc_tb_t;
   // AXI4-Lite write request bundle.
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } pcc_wreq_t;
   // Watchdog compare byte, match flags and interrupt enables supplied by the module datapath.
   typedef struct packed {
      logic [7:0] cmp_high;
      logic [5:0] match;
      logic [5:0] irq_en;
   } pcc_mod_t;
endpackage

//--- rtl/pcc_counter_control.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_cfg.svh"

// Overview of operation
// - Counter wrap sets the overflow flag.
// - Overflow flag requests interrupt when enabled.
// - Flags clear only by software zero write.
// - Run bit gates counter advance.
// - Module match or capture sets its flag.
// - Enabled module flags request the interrupt.
// - Idle suspend bit stops array in idle.
// - Watchdog enable uses module five as watchdog.
// - Lock bit forces watchdog on until reset.
// - Three-bit select picks the time base.
// - External input counts falling edges.
// - Oscillators divided by eight, synchronized.
// - Watchdog on freezes other mode bits.
// - Mode bit four reads zero always.
// - Watchdog compare match makes system reset.
// - Writing one to watchdog flag resets.
// - Watchdog forces counter to run.
// - Reset enables watchdog, divide-by-12 base.
module pcc_counter_control
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // AXI4-Lite write address channel.
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // System state and external time sources.
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic external_count_input,
   input wire logic ext_osc_clk,
   input wire logic rtc_osc_clk,
   // Module datapath hooks.
   input wire pcc_pkg::pcc_mod_t module_status,
   output logic [15:0] counter_value,
   output logic counter_tick,
   // Interrupt request and watchdog reset.
   output logic array_irq,
   output logic watchdog_reset
);
   import pcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers and state.

   logic counter_overflow_flag_q; // Sticky counter overflow flag.
   logic counter_run_control_q; // Software run request.
   logic [5:0] module_match_flags_q; // Sticky per-module flags.
   logic idle_suspend_bit_q; // Suspend array in idle.
   logic watchdog_enable_bit_q; // Watchdog active.
   logic watchdog_lock_bit_q; // Watchdog locked on.
   logic [2:0] timebase_select_q; // Counter time base.
   logic overflow_irq_enable_q; // Overflow interrupt mask.
   logic [15:0] count_q; // Array counter.
   logic [3:0] presc_q; // System clock prescaler.
   logic [2:0] ecnt_sync_q; // External count synchroniser.
   logic [2:0] eosc_sync_q; // External oscillator synchroniser.
   logic [2:0] rtc_sync_q; // Real-time oscillator synchroniser.
   logic [2:0] eosc_div_q; // External oscillator edge divider.
   logic [2:0] rtc_div_q; // Real-time oscillator edge divider.
   logic ecnt_prev_q; // Agreed external count level.
   logic eosc_prev_q; // Agreed external oscillator level.
   logic rtc_prev_q; // Agreed real-time oscillator level.
   logic wd_reset_q; // Registered watchdog reset pulse.
   logic aw_full_q; // Write address captured.
   logic w_full_q; // Write data captured.
   pcc_wreq_t wreq_q; // Captured write request.
   logic bvalid_q; // Write response pending.
   logic rvalid_q; // Read response pending.
   logic [31:0] rdata_q; // Read data register.
   logic tick; // Counter advance enable.
   logic running; // Counter allowed to advance.
   logic wr_fire; // Write is performed this cycle.
   logic ctrl_wr; // Write to the control register low lane.
   logic mode_wr; // Write to the mode register low lane.
   logic ecnt_fall; // Filtered falling edge of external count.
   logic eosc_rise; // Filtered rising edge of external oscillator.
   logic rtc_rise; // Filtered rising edge of real-time oscillator.

   // Reads the control register image.
   function automatic logic [7:0] ctrl_image(input logic ovf, input logic run,
                                             input logic [5:0] flags);
      ctrl_image = {ovf, run, flags};
   endfunction

   // Word index of a byte address; each register takes one aligned word.
   function automatic logic [7:0] word_index(input logic [9:0] byte_addr);
      word_index = byte_addr[9:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Time base generation.

   // Prescaler wraps at the ratio of the selected divided system clock.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         presc_q <= 4'h0;
      end else if (presc_q >= ((timebase_select_q == PCC_TB_DIV4) ?
                  `PCC_DIV4 - 4'd1 : `PCC_DIV12 - 4'd1)) begin
         presc_q <= 4'h0;
      end else begin
         presc_q <= presc_q + 4'h1;
      end
   end

   // Asynchronous sources pass three flops; a change counts once 2 and 3 agree.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ecnt_sync_q <= 3'h0;
         eosc_sync_q <= 3'h0;
         rtc_sync_q <= 3'h0;
         ecnt_prev_q <= 1'b0;
         eosc_prev_q <= 1'b0;
         rtc_prev_q <= 1'b0;
      end else begin
         ecnt_sync_q <= {ecnt_sync_q[1:0], external_count_input};
         eosc_sync_q <= {eosc_sync_q[1:0], ext_osc_clk};
         rtc_sync_q <= {rtc_sync_q[1:0], rtc_osc_clk};
         if (ecnt_sync_q[1] == ecnt_sync_q[2]) begin
            ecnt_prev_q <= ecnt_sync_q[2];
         end
         if (eosc_sync_q[1] == eosc_sync_q[2]) begin
            eosc_prev_q <= eosc_sync_q[2];
         end
         if (rtc_sync_q[1] == rtc_sync_q[2]) begin
            rtc_prev_q <= rtc_sync_q[2];
         end
      end
   end

   // Edge events from the agreed levels.
   assign ecnt_fall = ecnt_prev_q & (ecnt_sync_q[1] == ecnt_sync_q[2]) &
                      ~ecnt_sync_q[2];
   assign eosc_rise = ~eosc_prev_q & (eosc_sync_q[1] == eosc_sync_q[2]) &
                      eosc_sync_q[2];
   assign rtc_rise = ~rtc_prev_q & (rtc_sync_q[1] == rtc_sync_q[2]) &
                     rtc_sync_q[2];

   // Divide each oscillator by eight in the system domain.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         eosc_div_q <= 3'h0;
         rtc_div_q <= 3'h0;
      end else begin
         if (eosc_rise) begin
            eosc_div_q <= eosc_div_q + 3'h1;
         end
         if (rtc_rise) begin
            rtc_div_q <= rtc_div_q + 3'h1;
         end
      end
   end

   // Time base selection; the reserved code never advances the counter.
   always_comb begin
      case (pcc_tb_t'(timebase_select_q))
         PCC_TB_DIV12: tick = (presc_q == `PCC_DIV12 - 4'd1);
         PCC_TB_DIV4: tick = (presc_q >= `PCC_DIV4 - 4'd1);
         PCC_TB_T0OVF: tick = timer0_overflow;
         PCC_TB_EXTFALL: tick = ecnt_fall;
         PCC_TB_SYSCLK: tick = 1'b1;
         PCC_TB_EXTOSC: tick = eosc_rise & (eosc_div_q == `PCC_DIV8);
         PCC_TB_RTC: tick = rtc_rise & (rtc_div_q == `PCC_DIV8);
         default: tick = 1'b0;
      endcase
   end

   // Run gate: watchdog forces the counter on, idle suspend stops all.
   assign running = (counter_run_control_q |
                     watchdog_enable_bit_q) &
                    ~(idle_suspend_bit_q & cpu_idle);
   assign counter_tick = running & tick;

   ////////////////////////////////////////////////////////////////////////
   // Array counter.

   // Counter advances one per selected tick; software may load it when
   // the watchdog is off.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count_q <= 16'h0000;
      end else if (wr_fire && wreq_q.addr == `PCC_ADDR_CNT &&
                   !watchdog_enable_bit_q) begin
         count_q <= wreq_q.data[15:0];
      end else if (counter_tick) begin
         count_q <= count_q + 16'h0001;
      end
   end
   assign counter_value = count_q;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path.

   assign s_axi_awready = ~aw_full_q & ~bvalid_q;
   assign s_axi_wready = ~w_full_q & ~bvalid_q;
   assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
   assign ctrl_wr = wr_fire & (wreq_q.addr == `PCC_ADDR_CTRL) &
                    wreq_q.strb[0];
   assign mode_wr = wr_fire & (wreq_q.addr == `PCC_ADDR_MODE) &
                    wreq_q.strb[0];

   // Address and data are taken in either order, then performed once.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         wreq_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            wreq_q.addr <= word_index(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wreq_q.data <= s_axi_wdata;
            wreq_q.strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = 2'b00;

   ////////////////////////////////////////////////////////////////////////
   // Control and flag register.

   // Hardware sets win over a software clear in the same cycle.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         {counter_overflow_flag_q, counter_run_control_q,
          module_match_flags_q} <= `PCC_CTRL_RST;
      end else begin
         if (ctrl_wr) begin
            counter_overflow_flag_q <= wreq_q.data[`PCC_CTRL_OVF];
            counter_run_control_q <= wreq_q.data[`PCC_CTRL_RUN];
            module_match_flags_q <= wreq_q.data[5:0];
         end
         if (counter_tick && count_q == `PCC_CNT_MAX) begin
            counter_overflow_flag_q <= 1'b1;
         end
         if (!(idle_suspend_bit_q && cpu_idle)) begin
            module_match_flags_q <= (ctrl_wr ? wreq_q.data[5:0] :
                                     module_match_flags_q) |
                                    module_status.match;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode register.

   // Frozen while the watchdog runs; only the enable bit may be cleared,
   // and not once the lock is set.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         idle_suspend_bit_q <= 1'b0;
         watchdog_enable_bit_q <= 1'b1;
         watchdog_lock_bit_q <= 1'b0;
         timebase_select_q <= PCC_TB_DIV12;
         overflow_irq_enable_q <= 1'b0;
      end else if (mode_wr) begin
         if (!watchdog_enable_bit_q) begin
            idle_suspend_bit_q <= wreq_q.data[`PCC_MODE_IDLE];
            timebase_select_q <= wreq_q.data[`PCC_MODE_SEL_LO +: 3];
            overflow_irq_enable_q <= wreq_q.data[`PCC_MODE_OVIE];
            watchdog_lock_bit_q <= wreq_q.data[`PCC_MODE_LOCK];
            watchdog_enable_bit_q <= wreq_q.data[`PCC_MODE_WDEN] |
                                     wreq_q.data[`PCC_MODE_LOCK];
         end else if (!watchdog_lock_bit_q) begin
            watchdog_enable_bit_q <= wreq_q.data[`PCC_MODE_WDEN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog and interrupt.

   // Reset on high-byte match as the low byte wraps, or forced by software.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wd_reset_q <= 1'b0;
      end else begin
         wd_reset_q <= watchdog_enable_bit_q &
                       ((counter_tick && count_q[7:0] == 8'hff &&
                         module_status.cmp_high == count_q[15:8]) |
                        (ctrl_wr && wreq_q.data[`PCC_CTRL_WDF]));
      end
   end
   assign watchdog_reset = wd_reset_q;

   // One shared request line.
   assign array_irq = (overflow_irq_enable_q &
                       counter_overflow_flag_q) |
                      |(module_match_flags_q &
                        module_status.irq_en);

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path.

   assign s_axi_arready = ~rvalid_q;

   // One read at a time; unmapped addresses read zero with OKAY.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         if (word_index(s_axi_araddr) == `PCC_ADDR_CTRL) begin
            rdata_q <= {24'h000000, ctrl_image(counter_overflow_flag_q,
                        counter_run_control_q, module_match_flags_q)};
         end else if (word_index(s_axi_araddr) == `PCC_ADDR_MODE) begin
            rdata_q <= {24'h000000, idle_suspend_bit_q,
                        watchdog_enable_bit_q, watchdog_lock_bit_q,
                        1'b0, timebase_select_q,
                        overflow_irq_enable_q};
         end else if (word_index(s_axi_araddr) == `PCC_ADDR_CNT) begin
            rdata_q <= {16'h0000, count_q};
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = 2'b00;

endmodule
`default_nettype wire

//--- dv/pcc_counter_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Watches bus handshakes, counter steps and watchdog pulses at the ports.
module pcc_counter_control_monitor (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Write channels.
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels.
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // System and datapath side.
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic external_count_input,
   input wire logic ext_osc_clk,
   input wire logic rtc_osc_clk,
   input wire pcc_pkg::pcc_mod_t module_status,
   input wire logic [15:0] counter_value,
   input wire logic counter_tick,
   input wire logic array_irq,
   input wire logic watchdog_reset
);
   import pcc_pkg::*;
   // All checks share the system clock and its reset.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // A write is performed in the cycle where both readies and bvalid are low.
   aw_refuse_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   b_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid &&
      s_axi_bresp == 2'b00)
      else $error("write response late or not okay");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rresp == 2'b00)
      else $error("read data late or not okay");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   tick_step_a: assert property (
      counter_tick && (s_axi_awready || s_axi_wready || s_axi_bvalid) |=>
      counter_value == $past(counter_value) + 16'h0001)
      else $error("counter did not step on tick");
   count_hold_a: assert property (
      !counter_tick && (s_axi_awready || s_axi_wready || s_axi_bvalid) |=>
      $stable(counter_value))
      else $error("counter moved without tick");
   wrap_zero_a: assert property (
      counter_tick && (s_axi_awready || s_axi_wready || s_axi_bvalid) &&
      counter_value == 16'hffff |=> counter_value == 16'h0000)
      else $error("counter did not wrap to zero");
   wd_pulse_a: assert property (watchdog_reset |=> !watchdog_reset)
      else $error("watchdog reset longer than one cycle");
   reset_state_a: assert property ($fell(reset) |-> !s_axi_bvalid &&
      !s_axi_rvalid && counter_value == 16'h0000 && !array_irq &&
      !watchdog_reset)
      else $error("outputs not at reset state");
endmodule
bind pcc_counter_control pcc_counter_control_monitor u_mon (.*);
`default_nettype wire

//--- dv/tb_pcc_counter_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcc_cfg.svh"
module tb_pcc_counter_control;
   import pcc_pkg::*;
   // Design ports.
   logic clk_sys, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_idle;
   logic timer0_overflow, external_count_input, ext_osc_clk, rtc_osc_clk;
   logic counter_tick, array_irq, watchdog_reset;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [31:0] cyc = 32'h0;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] counter_value;
   pcc_mod_t module_status;
   // Bookkeeping; bounds of ticks per 96 cycles for each time base code.
   int failures = 0;
   int n_tests = 0;
   int cnt, n_wd = 0, w0;
   int exp_lo [8] = '{7, 23, 11, 5, 95, 1, 0, 0};
   int exp_hi [8] = '{9, 25, 13, 7, 97, 3, 2, 0};
   pcc_counter_control dut (.*);
   ////////////////////////////////////////
   // Free-running clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Time sources: timer pulse every 8, input falls every 16, oscillators.
   always @(posedge clk_sys) begin
      cyc <= cyc + 32'h1;
      timer0_overflow <= (cyc[2:0] == 3'h0);
      external_count_input <= cyc[3];
      ext_osc_clk <= (cyc % 6) < 3;
      rtc_osc_clk <= (cyc % 10) < 5;
      if (watchdog_reset === 1'b1) n_wd <= n_wd + 1;
   end
   ////////////////////////////////////////
   task automatic results;
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Compares a value against an inclusive range.
   task automatic chk(input logic [31:0] got, input logic [31:0] lo,
                      input logic [31:0] hi);
      logic ok;
      ok = (got >= lo) && (got <= hi);
      n_tests++;
      if (ok !== 1'b1) begin
         failures++;
         $display("MISMATCH at %0t: got %0h want %0h..%0h", $time, got, lo, hi);
      end
   endtask
   // Offers address and data together, releases each once taken.
   // The argument is the register's word index; the byte address is 4x.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Reads one word into rd.
   task automatic axi_rd(input logic [7:0] a);
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Counts counter advances over n cycles.
   task automatic ticks(input int n);
      cnt = 0;
      repeat (n) begin
         @(posedge clk_sys);
         if (counter_tick === 1'b1) cnt++;
      end
   endtask
   task automatic do_reset;
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
   endtask
   ////////////////////////////////////////
   // Hang guard.
   initial begin
      #200us;
      failures++;
      $display("MISMATCH at %0t: timeout", $time);
      results;
   end
   // Main sequence.
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_rready, cpu_idle} = 2'h0;
      s_axi_wstrb = 4'hf;
      module_status = '0;
      reset = 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      axi_rd(`PCC_ADDR_CTRL);
      chk(rd, 32'h00, 32'h00);
      axi_rd(`PCC_ADDR_MODE);
      chk(rd, 32'h40, 32'h40);
      ticks(120);
      chk(cnt, 10, 10);
      axi_wr(`PCC_ADDR_MODE, 32'hce);
      axi_rd(`PCC_ADDR_MODE);
      chk(rd, 32'h40, 32'h40);
      axi_wr(`PCC_ADDR_MODE, 32'h00);
      axi_wr(`PCC_ADDR_MODE, 32'h1e);
      axi_rd(`PCC_ADDR_MODE);
      chk(rd, 32'h0e, 32'h0e);
      axi_rd(8'he4);
      chk(rd, 32'h0, 32'h0);
      axi_wr(`PCC_ADDR_MODE, 32'h08);
      ticks(50);
      chk(cnt, 0, 0);
      axi_wr(`PCC_ADDR_CTRL, 32'h40);
      ticks(50);
      chk(cnt, 50, 50);
      // Every time base code, run bit set.
      for (int i = 0; i < 8; i++) begin
         axi_wr(`PCC_ADDR_MODE, 32'(i) << 1);
         ticks(96);
         chk(cnt, exp_lo[i], exp_hi[i]);
      end
      // Overflow flag and its interrupt.
      axi_wr(`PCC_ADDR_MODE, 32'h09);
      axi_wr(`PCC_ADDR_CNT, 32'hfff0);
      repeat (40) @(posedge clk_sys);
      axi_rd(`PCC_ADDR_CTRL);
      chk(rd[7], 1, 1);
      chk(array_irq, 1, 1);
      axi_wr(`PCC_ADDR_MODE, 32'h08);
      chk(array_irq, 0, 0);
      axi_rd(`PCC_ADDR_CTRL);
      chk(rd[7], 1, 1);
      axi_wr(`PCC_ADDR_CTRL, 32'h40);
      axi_rd(`PCC_ADDR_CTRL);
      chk(rd, 32'h40, 32'h40);
      // Module match flag and its interrupt.
      module_status.match <= 6'h04;
      @(posedge clk_sys);
      module_status.match <= 6'h00;
      axi_rd(`PCC_ADDR_CTRL);
      chk(rd, 32'h44, 32'h44);
      chk(array_irq, 0, 0);
      module_status.irq_en <= 6'h04;
      repeat (2) @(posedge clk_sys);
      chk(array_irq, 1, 1);
      axi_wr(`PCC_ADDR_CTRL, 32'h40);
      chk(array_irq, 0, 0);
      // Idle suspension.
      axi_wr(`PCC_ADDR_MODE, 32'h88);
      cpu_idle <= 1'b1;
      ticks(20);
      chk(cnt, 0, 0);
      axi_wr(`PCC_ADDR_MODE, 32'h08);
      ticks(20);
      chk(cnt, 20, 20);
      cpu_idle <= 1'b0;
      // Watchdog on module five: forced run, compare match, forced reset.
      axi_wr(`PCC_ADDR_CNT, 32'h0);
      module_status.cmp_high <= 8'h01;
      axi_wr(`PCC_ADDR_MODE, 32'h48);
      axi_wr(`PCC_ADDR_CTRL, 32'h00);
      ticks(20);
      chk(cnt, 20, 20);
      w0 = n_wd;
      while (counter_value < 16'h01fe) @(posedge clk_sys);
      chk(n_wd - w0, 0, 0);
      while (counter_value < 16'h0204) @(posedge clk_sys);
      chk(n_wd - w0, 1, 1);
      w0 = n_wd;
      axi_wr(`PCC_ADDR_CTRL, 32'h20);
      repeat (2) @(posedge clk_sys);
      chk(n_wd - w0, 1, 1);
      // Lock holds the watchdog on until reset.
      axi_wr(`PCC_ADDR_MODE, 32'h00);
      axi_wr(`PCC_ADDR_MODE, 32'h20);
      axi_rd(`PCC_ADDR_MODE);
      chk(rd & 32'h60, 32'h60, 32'h60);
      axi_wr(`PCC_ADDR_MODE, 32'h00);
      axi_rd(`PCC_ADDR_MODE);
      chk(rd & 32'h60, 32'h60, 32'h60);
      do_reset();
      axi_rd(`PCC_ADDR_MODE);
      chk(rd, 32'h40, 32'h40);
      results;
   end
endmodule
`default_nettype wire
